//--- core/preset_jog_pkg.sv
// Constants, types and helpers for the preset speed and jog selector
// Notes on behaviour
// - Binary select: first input weight 1, second 2
// - Unassigned binary select input reads as off
// - Binary index taken after settle time, edges restart
// - Mode 01 uses seven bit inputs, speeds 0-7
// - Bit mode: lowest active input wins
// - All selects off gives speed 0 from source
// - Only third bit input gives speed 3, monitored
// - Jog before run starts jog operation
// - Jog frequency direct, no ramp, min..10.00 Hz
// - Jog overrides source, presets, forced inputs
// - Jog stop mode: 0-2 forbid, 3-5 allow
// - Forbid group: run first blocks jog
// - Allow group: jog during run, early release coasts
// - Speed 0 and jog settings have second-motor copies
// - Mode 00 decodes four inputs as 0-15
// - Settle time 0 to 200 times 10 ms
// - Nonzero preset overrides frequency source
package preset_jog_pkg;

  localparam int CLK_HZ         = 40_000_000;
  localparam int SETTLE_STEP_MS = 10;
  localparam int SETTLE_TICK_CYC = CLK_HZ / 1000 * SETTLE_STEP_MS;

  localparam logic [7:0]  SETTLE_MAX   = 8'hC8;    // 200 steps
  localparam logic [15:0] JOG_FREQ_MAX = 16'h03E8; // 10.00 Hz in 0.01 Hz

  localparam logic [1:0] MODE_BINARY = 2'h0;
  localparam logic [1:0] MODE_BIT    = 2'h1;
  localparam logic [2:0] SRC_PARAM   = 3'h2;

  // Register offsets (word index)
  localparam logic [5:0] OFS_MODE      = 6'h00;
  localparam logic [5:0] OFS_SETTLE    = 6'h01;
  localparam logic [5:0] OFS_FREQ_SRC  = 6'h02;
  localparam logic [5:0] OFS_MIN_FREQ  = 6'h03;
  localparam logic [5:0] OFS_JOG_FREQ1 = 6'h04;
  localparam logic [5:0] OFS_JOG_STOP1 = 6'h05;
  localparam logic [5:0] OFS_JOG_FREQ2 = 6'h06;
  localparam logic [5:0] OFS_JOG_STOP2 = 6'h07;
  localparam logic [5:0] OFS_SPEED0_2  = 6'h08;
  localparam logic [5:0] OFS_BIN_ASGN  = 6'h09;
  localparam logic [5:0] OFS_BIT_ASGN  = 6'h0A;
  localparam logic [5:0] OFS_MONITOR   = 6'h0B;
  localparam logic [5:0] OFS_STATUS    = 6'h0C;
  localparam logic [5:0] OFS_TABLE     = 6'h10;

  // Reset values
  localparam logic [15:0] RST_MIN_FREQ = 16'h0000;
  localparam logic [15:0] RST_JOG_FREQ = 16'h0064;
  localparam logic [2:0]  RST_JOG_STOP = 3'h0;
  localparam logic [2:0]  RST_FREQ_SRC = 3'h2;
  localparam logic [3:0]  RST_BIN_ASGN = 4'hF;
  localparam logic [6:0]  RST_BIT_ASGN = 7'h7F;

  typedef enum logic [1:0] {
    STOP_FREE   = 2'b00,
    STOP_DECEL  = 2'b01,
    STOP_DCBRK  = 2'b10
  } stop_kind_t;

  typedef enum logic [1:0] {
    JS_IDLE = 2'b00,
    JS_RUN  = 2'b01,
    JS_JOG  = 2'b10,
    JS_HOLD = 2'b11
  } jog_state_t;

  // Lowest active bit input wins; none gives 0
  function automatic logic [3:0] prio_speedbit(input logic [6:0] b);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 6; i >= 0; i--) begin
      if (b[i]) r = 4'(i + 1);
    end
    return r;
  endfunction

  // Codes 3..5 permit jog while running
  function automatic logic jog_allow(input logic [2:0] m);
    return (m >= 3'h3) && (m <= 3'h5);
  endfunction

  // Stop kind cycles free, decel, DC brake per group
  function automatic stop_kind_t jog_kind(input logic [2:0] m);
    stop_kind_t k;
    k = STOP_FREE;
    if (m == 3'h1 || m == 3'h4) k = STOP_DECEL;
    else if (m == 3'h2 || m == 3'h5) k = STOP_DCBRK;
    return k;
  endfunction

  // Jog frequency held between minimum and 10.00 Hz
  function automatic logic [15:0] clamp_jog(input logic [15:0] f,
                                            input logic [15:0] fmin);
    logic [15:0] r;
    r = (f > JOG_FREQ_MAX) ? JOG_FREQ_MAX : f;
    if (r < fmin) r = fmin;
    return r;
  endfunction

endpackage

//--- core/preset_index_decoder.sv
// Speed index decoder with binary settle timer
`timescale 1ns/1ps
module preset_index_decoder #(
  parameter int SETTLE_TICK = preset_jog_pkg::SETTLE_TICK_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] settle,
  input  wire logic [3:0] binsel,
  input  wire logic [6:0] speedbit,
  output logic      [3:0] speed_index
);

  typedef struct packed {
    logic [3:0]  index;
    logic [3:0]  prev_bin;
    logic        pending;
    logic [18:0] tick;
    logic [7:0]  units;
  } dec_state_t;

  dec_state_t st;
  dec_state_t next_st;

  // Settling wait restarts on every edge of any assigned binary select input
  always_comb begin
    next_st = st;
    next_st.prev_bin = binsel;
    if (mode == preset_jog_pkg::MODE_BIT) begin
      next_st.pending = 1'b0;
      next_st.index   = preset_jog_pkg::prio_speedbit(speedbit);
    end else if (binsel != st.prev_bin) begin
      next_st.pending = 1'b1;
      next_st.tick    = 19'h00000;
      next_st.units   = 8'h00;
    end else if (st.pending) begin
      if (st.units >= settle) begin
        next_st.pending = 1'b0;
        next_st.index   = binsel;
      end else if (st.tick == 19'(SETTLE_TICK - 1)) begin
        next_st.tick  = 19'h00000;
        next_st.units = st.units + 8'h01;
      end else begin
        next_st.tick = st.tick + 19'h00001;
      end
    end else if (st.index != binsel) begin
      // Catches a mode switch back to binary with steady inputs; full wait again
      next_st.pending = 1'b1;
      next_st.tick    = 19'h00000;
      next_st.units   = 8'h00;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign speed_index = st.index;

endmodule // preset_index_decoder

//--- core/preset_speed_jog_selector.sv
// Preset speed and jog frequency command selector
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module preset_speed_jog_selector #(
  parameter int SETTLE_TICK = preset_jog_pkg::SETTLE_TICK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Selector terminals
  input  wire logic        binsel_bit0,
  input  wire logic        binsel_bit1,
  input  wire logic        binsel_bit2,
  input  wire logic        binsel_bit3,
  input  wire logic        speedbit_in1,
  input  wire logic        speedbit_in2,
  input  wire logic        speedbit_in3,
  input  wire logic        speedbit_in4,
  input  wire logic        speedbit_in5,
  input  wire logic        speedbit_in6,
  input  wire logic        speedbit_in7,
  // Run and override terminals
  input  wire logic        run_cmd,
  input  wire logic        jog_input,
  input  wire logic        motor2_select,
  input  wire logic        forced_terminal_input,
  input  wire logic        forced_operation_input,
  // Frequency sources, 0.01 Hz units
  input  wire logic [15:0] source_freq_cmd,
  input  wire logic [15:0] terminal_freq_cmd,
  input  wire logic [15:0] operator_freq_cmd,
  // Results
  output logic      [15:0] freq_cmd,
  output logic             ramp_bypass,
  output logic             jog_active,
  output logic             stop_req,
  output logic      [1:0]  stop_kind,
  output logic      [3:0]  speed_index
);

  //////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]        preset_mode_select;
    logic [7:0]        preset_settle_time;
    logic [2:0]        freq_source_select;
    logic [15:0]       min_freq;
    logic [1:0][15:0]  jog_frequency;
    logic [1:0][2:0]   jog_stop_mode;
    logic [15:0]       speed0_second;
    logic [3:0]        bin_assign;
    logic [6:0]        bit_assign;
    logic [15:0][15:0] speed_table;
    preset_jog_pkg::jog_state_t js;
    logic [15:0]       freq;
    logic              bypass;
    logic              jog;
    logic              stop;
    logic [1:0]        kind;
    logic [15:0]       rdata;
  } sel_state_t;

  sel_state_t st;
  sel_state_t next_st;

  logic [3:0]  idx;
  logic [3:0]  bin_raw;
  logic [6:0]  bit_raw;
  logic        msel;
  logic [15:0] jog_f;
  logic [2:0]  jog_m;
  logic [15:0] speed0;

  //////////////////////////////////////////////////////////////////////
  // Terminal gathering
  // Unassigned selects are masked so a floating pin cannot pick a speed
  assign bin_raw = {binsel_bit3, binsel_bit2, binsel_bit1, binsel_bit0}
                   & st.bin_assign;
  assign bit_raw = {speedbit_in7, speedbit_in6, speedbit_in5,
                    speedbit_in4, speedbit_in3, speedbit_in2,
                    speedbit_in1} & st.bit_assign;

  // Second-motor copies of speed 0 and jog settings
  assign msel  = motor2_select;
  assign jog_f = st.jog_frequency[msel];
  assign jog_m = st.jog_stop_mode[msel];
  assign speed0 = msel ? st.speed0_second : st.speed_table[0];

  //////////////////////////////////////////////////////////////////////
  // Index decoder
  preset_index_decoder #(
    .SETTLE_TICK (SETTLE_TICK)
  ) u_decoder (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .ce          (ce),
    .mode        (st.preset_mode_select),
    .settle      (st.preset_settle_time),
    .binsel      (bin_raw),
    .speedbit    (bit_raw),
    .speed_index (idx)
  );

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.stop = 1'b0;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == preset_jog_pkg::OFS_MODE) begin
        next_st.preset_mode_select = reg_wdata[1:0];
      end else if (reg_addr == preset_jog_pkg::OFS_SETTLE) begin
        // Out-of-range settle values saturate rather than wrap
        if (reg_wdata[7:0] > preset_jog_pkg::SETTLE_MAX) begin
          next_st.preset_settle_time = preset_jog_pkg::SETTLE_MAX;
        end else begin
          next_st.preset_settle_time = reg_wdata[7:0];
        end
      end else if (reg_addr == preset_jog_pkg::OFS_FREQ_SRC) begin
        next_st.freq_source_select = reg_wdata[2:0];
      end else if (reg_addr == preset_jog_pkg::OFS_MIN_FREQ) begin
        next_st.min_freq = reg_wdata;
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_FREQ1) begin
        next_st.jog_frequency[0] = reg_wdata;
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_STOP1) begin
        next_st.jog_stop_mode[0] = reg_wdata[2:0];
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_FREQ2) begin
        next_st.jog_frequency[1] = reg_wdata;
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_STOP2) begin
        next_st.jog_stop_mode[1] = reg_wdata[2:0];
      end else if (reg_addr == preset_jog_pkg::OFS_SPEED0_2) begin
        next_st.speed0_second = reg_wdata;
      end else if (reg_addr == preset_jog_pkg::OFS_BIN_ASGN) begin
        next_st.bin_assign = reg_wdata[3:0];
      end else if (reg_addr == preset_jog_pkg::OFS_BIT_ASGN) begin
        next_st.bit_assign = reg_wdata[6:0];
      end else if (reg_addr == preset_jog_pkg::OFS_MONITOR) begin
        // Writing the monitor edits the entry now selected
        if (idx == 4'h0 && msel) begin
          next_st.speed0_second = reg_wdata;
        end else begin
          next_st.speed_table[idx] = reg_wdata;
        end
      end else if (reg_addr[5:4] == preset_jog_pkg::OFS_TABLE[5:4]) begin
        next_st.speed_table[reg_addr[3:0]] = reg_wdata;
      end
    end

    // Register reads, data valid the next cycle
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == preset_jog_pkg::OFS_MODE) begin
        next_st.rdata = {14'h0000, st.preset_mode_select};
      end else if (reg_addr == preset_jog_pkg::OFS_SETTLE) begin
        next_st.rdata = {8'h00, st.preset_settle_time};
      end else if (reg_addr == preset_jog_pkg::OFS_FREQ_SRC) begin
        next_st.rdata = {13'h0000, st.freq_source_select};
      end else if (reg_addr == preset_jog_pkg::OFS_MIN_FREQ) begin
        next_st.rdata = st.min_freq;
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_FREQ1) begin
        next_st.rdata = st.jog_frequency[0];
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_STOP1) begin
        next_st.rdata = {13'h0000, st.jog_stop_mode[0]};
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_FREQ2) begin
        next_st.rdata = st.jog_frequency[1];
      end else if (reg_addr == preset_jog_pkg::OFS_JOG_STOP2) begin
        next_st.rdata = {13'h0000, st.jog_stop_mode[1]};
      end else if (reg_addr == preset_jog_pkg::OFS_SPEED0_2) begin
        next_st.rdata = st.speed0_second;
      end else if (reg_addr == preset_jog_pkg::OFS_BIN_ASGN) begin
        next_st.rdata = {12'h000, st.bin_assign};
      end else if (reg_addr == preset_jog_pkg::OFS_BIT_ASGN) begin
        next_st.rdata = {9'h000, st.bit_assign};
      end else if (reg_addr == preset_jog_pkg::OFS_MONITOR) begin
        next_st.rdata = st.freq;
      end else if (reg_addr == preset_jog_pkg::OFS_STATUS) begin
        next_st.rdata = {8'h00, st.kind, st.js, idx};
      end else if (reg_addr[5:4] == preset_jog_pkg::OFS_TABLE[5:4]) begin
        next_st.rdata = st.speed_table[reg_addr[3:0]];
      end
    end

    // Jog sequencing
    case (st.js)
      preset_jog_pkg::JS_IDLE: begin
        if (run_cmd && jog_input) begin
          next_st.js = preset_jog_pkg::JS_JOG;
        end else if (run_cmd) begin
          next_st.js = preset_jog_pkg::JS_RUN;
        end
      end
      preset_jog_pkg::JS_RUN: begin
        if (!run_cmd) begin
          next_st.js = preset_jog_pkg::JS_IDLE;
        end else if (jog_input && preset_jog_pkg::jog_allow(jog_m)) begin
          next_st.js = preset_jog_pkg::JS_JOG;
        end
        // Forbid group keeps running normally with jog ignored
      end
      preset_jog_pkg::JS_JOG: begin
        if (!run_cmd) begin
          next_st.js   = preset_jog_pkg::JS_IDLE;
          next_st.stop = 1'b1;
          next_st.kind = preset_jog_pkg::jog_kind(jog_m);
        end else if (!jog_input) begin
          // Jog dropped under run: coast, then wait for run to clear
          next_st.js   = preset_jog_pkg::JS_HOLD;
          next_st.stop = 1'b1;
          next_st.kind = preset_jog_pkg::STOP_FREE;
        end
      end
      preset_jog_pkg::JS_HOLD: begin
        if (!run_cmd) begin
          next_st.js = preset_jog_pkg::JS_IDLE;
        end
      end
      default: begin
        next_st.js = preset_jog_pkg::JS_IDLE;
      end
    endcase

    // Frequency command priority, jog first
    next_st.jog    = (next_st.js == preset_jog_pkg::JS_JOG);
    next_st.bypass = next_st.jog;
    if (next_st.jog) begin
      next_st.freq = preset_jog_pkg::clamp_jog(jog_f, st.min_freq);
    end else if (next_st.js == preset_jog_pkg::JS_HOLD) begin
      next_st.freq = 16'h0000;
    end else if (forced_terminal_input) begin
      next_st.freq = terminal_freq_cmd;
    end else if (forced_operation_input) begin
      next_st.freq = operator_freq_cmd;
    end else if (idx != 4'h0) begin
      next_st.freq = st.speed_table[idx];
    end else if (st.freq_source_select == preset_jog_pkg::SRC_PARAM) begin
      next_st.freq = speed0;
    end else begin
      next_st.freq = source_freq_cmd;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st                    <= '0;
      st.freq_source_select <= preset_jog_pkg::RST_FREQ_SRC;
      st.min_freq           <= preset_jog_pkg::RST_MIN_FREQ;
      st.jog_frequency[0]   <= preset_jog_pkg::RST_JOG_FREQ;
      st.jog_frequency[1]   <= preset_jog_pkg::RST_JOG_FREQ;
      st.jog_stop_mode[0]   <= preset_jog_pkg::RST_JOG_STOP;
      st.jog_stop_mode[1]   <= preset_jog_pkg::RST_JOG_STOP;
      st.bin_assign         <= preset_jog_pkg::RST_BIN_ASGN;
      st.bit_assign         <= preset_jog_pkg::RST_BIT_ASGN;
      st.js                 <= preset_jog_pkg::JS_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign reg_rdata   = st.rdata;
  assign freq_cmd    = st.freq;
  assign ramp_bypass = st.bypass;
  assign jog_active  = st.jog;
  assign stop_req    = st.stop;
  assign stop_kind   = st.kind;
  assign speed_index = idx;

endmodule // preset_speed_jog_selector

//--- testbench/preset_jog_chk.sv
// Port-level assertions for the preset speed and jog selector
`timescale 1ns/1ps
module preset_jog_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        run_cmd,
  input wire logic        jog_input,
  input wire logic [15:0] freq_cmd,
  input wire logic        ramp_bypass,
  input wire logic        jog_active,
  input wire logic        stop_req,
  input wire logic [1:0]  stop_kind
);
  // Clock enable is held high by the bench, so cycles map one to one
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its answer cycle");
  AST_STOP_PULSE: assert property (stop_req |=> !stop_req)
    else $error("stop request longer than one cycle");
  AST_BYPASS: assert property (ramp_bypass == jog_active)
    else $error("ramp bypass differs from jog state");
  AST_JOG_LIMIT: assert property (jog_active |-> freq_cmd <= 16'h03E8)
    else $error("jog frequency above its ceiling");
  AST_EXIT_STOP: assert property ($fell(jog_active) |-> stop_req)
    else $error("jog ended without a stop request");
  AST_ENTER_JOG: assert property ($rose(jog_active) |-> $past(run_cmd) && $past(jog_input))
    else $error("jog entered without run and jog inputs");
  AST_NO_RUN_NO_JOG: assert property (!run_cmd |=> !jog_active)
    else $error("jog active one cycle after run dropped");
  AST_COAST: assert property ($fell(jog_active) && $past(run_cmd) |->
                              stop_kind == 2'b00 && freq_cmd == 16'h0000)
    else $error("early jog release did not coast");
  AST_JOG_KEEP: assert property (jog_active && jog_input && run_cmd |=> jog_active)
    else $error("jog left while both inputs held");

  // Main scenarios reached
  cover property ($rose(jog_active));
  cover property (stop_req && stop_kind == 2'b10);
  cover property ($fell(jog_active) && $past(run_cmd));
endmodule // preset_jog_chk

bind preset_speed_jog_selector preset_jog_chk u_preset_jog_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .run_cmd(run_cmd), .jog_input(jog_input), .freq_cmd(freq_cmd),
  .ramp_bypass(ramp_bypass), .jog_active(jog_active), .stop_req(stop_req),
  .stop_kind(stop_kind)
);

//--- testbench/terminal_panel.sv
// Model of the switches and controller wired to the input terminals
`timescale 1ns/1ps
module terminal_panel (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] want_binsel,
  input  wire logic [6:0] want_speedbit,
  input  wire logic       want_jog,
  input  wire logic       want_run,
  output logic      [3:0] binsel,
  output logic      [6:0] speedbit,
  output logic            jog,
  output logic            run
);
  // Contacts follow commands one cycle late; a run asked with jog waits for jog
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      binsel   <= 4'h0;
      speedbit <= 7'h00;
      jog      <= 1'b0;
      run      <= 1'b0;
    end else begin
      binsel   <= want_binsel;
      speedbit <= want_speedbit;
      jog      <= want_jog;
      run      <= want_run && (run || jog || !want_jog);
    end
  end
endmodule // terminal_panel

//--- testbench/preset_speed_jog_selector_tb.sv
// Self-checking bench for the preset speed and jog selector
`timescale 1ns/1ps
module preset_speed_jog_selector_tb;
  logic        sys_clk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [3:0]  want_binsel;
  logic [6:0]  want_speedbit;
  logic        want_jog;
  logic        want_run;
  logic [3:0]  binsel;
  logic [6:0]  speedbit;
  logic        jog;
  logic        run;
  logic        motor2_select;
  logic        forced_terminal_input;
  logic        forced_operation_input;
  logic [15:0] freq_cmd;
  logic        ramp_bypass;
  logic        jog_active;
  logic        stop_req;
  logic [1:0]  stop_kind;
  logic [3:0]  speed_index;
  int          num_errors;
  int          checks_done;
  int          cycles;

  // Short settle tick keeps binary waits to about a dozen cycles
  preset_speed_jog_selector #(.SETTLE_TICK(4)) u_preset_speed_jog_selector (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .binsel_bit0(binsel[0]), .binsel_bit1(binsel[1]), .binsel_bit2(binsel[2]),
    .binsel_bit3(binsel[3]), .speedbit_in1(speedbit[0]), .speedbit_in2(speedbit[1]),
    .speedbit_in3(speedbit[2]), .speedbit_in4(speedbit[3]), .speedbit_in5(speedbit[4]),
    .speedbit_in6(speedbit[5]), .speedbit_in7(speedbit[6]), .run_cmd(run),
    .jog_input(jog), .motor2_select(motor2_select),
    .forced_terminal_input(forced_terminal_input),
    .forced_operation_input(forced_operation_input), .source_freq_cmd(16'h1111),
    .terminal_freq_cmd(16'h2222), .operator_freq_cmd(16'h3333), .freq_cmd(freq_cmd),
    .ramp_bypass(ramp_bypass), .jog_active(jog_active), .stop_req(stop_req),
    .stop_kind(stop_kind), .speed_index(speed_index));

  terminal_panel u_terminal_panel (
    .sys_clk(sys_clk), .rst(rst), .want_binsel(want_binsel), .want_speedbit(want_speedbit),
    .want_jog(want_jog), .want_run(want_run), .binsel(binsel), .speedbit(speedbit),
    .jog(jog), .run(run));

  ////////////////////////////////////////
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  task automatic pins(input logic [3:0] b, input logic [6:0] s, input logic j, input logic r);
    @(posedge sys_clk);
    want_binsel   <= b;
    want_speedbit <= s;
    want_jog      <= j;
    want_run      <= r;
  endtask

  // Bounded wait for a settled binary index
  task automatic bin_expect(input logic [3:0] b, input logic [3:0] e, input string what);
    int n;
    pins(b, 7'h00, 1'b0, 1'b0);
    step(4);
    check({what, " early"}, 16'h0000, 16'(speed_index));
    n = 0;
    while (speed_index !== e && n < 60) begin
      step(1);
      n++;
    end
    check(what, 16'(e), 16'(speed_index));
    step(1);
    check({what, " freq"}, 16'h0100 + 16'(e), freq_cmd);
    pins(4'h0, 7'h00, 1'b0, 1'b0);
    step(20);
  endtask

  ////////////////////////////////////////
  task automatic t_registers();
    rd(preset_jog_pkg::OFS_JOG_FREQ1, 16'h0064, "jog freq reset");
    rd(preset_jog_pkg::OFS_BIN_ASGN, 16'h000F, "bin assign reset");
    rd(preset_jog_pkg::OFS_FREQ_SRC, 16'h0002, "freq source reset");
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F, 16'h0000, "unmapped read");
    wr(preset_jog_pkg::OFS_SETTLE, 16'h00FF);
    rd(preset_jog_pkg::OFS_SETTLE, 16'h00C8, "settle ceiling");
    wr(preset_jog_pkg::OFS_SETTLE, 16'h0003);
    for (int i = 0; i < 16; i++) begin
      wr(preset_jog_pkg::OFS_TABLE + 6'(i), 16'h0100 + 16'(i));
    end
  endtask

  task automatic t_binary();
    wr(preset_jog_pkg::OFS_FREQ_SRC, 16'h0000);
    step(3);
    check("source at speed 0", 16'h1111, freq_cmd);
    bin_expect(4'b0010, 4'h2, "second input alone");
    bin_expect(4'b1011, 4'hB, "four input code");
    wr(preset_jog_pkg::OFS_BIN_ASGN, 16'h0003);
    bin_expect(4'b1101, 4'h1, "unassigned inputs");
    wr(preset_jog_pkg::OFS_BIN_ASGN, 16'h000F);
    wr(preset_jog_pkg::OFS_FREQ_SRC, 16'h0002);
  endtask

  task automatic t_bit();
    wr(preset_jog_pkg::OFS_MODE, 16'h0001);
    for (int k = 0; k < 7; k++) begin
      pins(4'h0, 7'(7'h7F << k), 1'b0, 1'b0);
      step(2);
      check("bit index", 16'(k + 1), 16'(speed_index));
      step(1);
      check("bit freq", 16'h0101 + 16'(k), freq_cmd);
    end
    pins(4'h0, 7'b0000100, 1'b0, 1'b0);
    step(3);
    rd(preset_jog_pkg::OFS_MONITOR, 16'h0103, "monitor speed 3");
    pins(4'h0, 7'h00, 1'b0, 1'b0);
    step(3);
    check("all off speed 0", 16'h0100, freq_cmd);
    wr(preset_jog_pkg::OFS_MODE, 16'h0000);
  endtask

  task automatic t_jog();
    wr(preset_jog_pkg::OFS_JOG_FREQ1, 16'h07D0);
    forced_operation_input <= 1'b1;
    step(3);
    check("forced operation", 16'h3333, freq_cmd);
    forced_terminal_input <= 1'b1;
    step(3);
    check("forced terminal", 16'h2222, freq_cmd);
    for (int m = 0; m < 6; m++) begin
      wr(preset_jog_pkg::OFS_JOG_STOP1, 16'(m));
      pins(4'h0, 7'h01, 1'b1, 1'b1);
      step(3);
      check("jog active", 16'h0001, 16'(jog_active));
      check("jog freq", preset_jog_pkg::JOG_FREQ_MAX, freq_cmd);
      pins(4'h0, 7'h01, 1'b1, 1'b0);
      step(2);
      check("stop request", 16'h0001, 16'(stop_req));
      check("stop kind", 16'(m % 3), 16'(stop_kind));
      pins(4'h0, 7'h00, 1'b0, 1'b0);
      step(2);
    end
    forced_terminal_input  <= 1'b0;
    forced_operation_input <= 1'b0;
  endtask

  // Run first, then jog: blocked in one group, taken in the other
  task automatic t_run_first();
    for (int p = 0; p < 2; p++) begin
      wr(preset_jog_pkg::OFS_JOG_STOP1, 16'(p * 4));
      pins(4'h0, 7'h00, 1'b0, 1'b1);
      step(2);
      pins(4'h0, 7'h00, 1'b1, 1'b1);
      step(3);
      check("jog after run", 16'(p), 16'(jog_active));
      pins(4'h0, 7'h00, 1'b0, 1'b1);
      step(2);
      if (p == 1) begin
        check("coast kind", 16'h0000, 16'(stop_kind));
        check("coast freq", 16'h0000, freq_cmd);
      end
      pins(4'h0, 7'h00, 1'b0, 1'b0);
      step(3);
    end
  endtask

  task automatic t_motor2();
    wr(preset_jog_pkg::OFS_JOG_FREQ2, 16'h0200);
    wr(preset_jog_pkg::OFS_SPEED0_2, 16'h0155);
    motor2_select <= 1'b1;
    step(3);
    check("second speed 0", 16'h0155, freq_cmd);
    pins(4'h0, 7'h00, 1'b1, 1'b1);
    step(3);
    check("second jog freq", 16'h0200, freq_cmd);
    pins(4'h0, 7'h00, 1'b0, 1'b0);
    step(3);
    motor2_select <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles > 20000) begin
        num_errors++;
        tally_and_finish();
      end
    end
  end

  // Main sequence
  initial begin
    num_errors             = 0;
    checks_done            = 0;
    rst                    = 1'b1;
    reg_wr                 = 1'b0;
    reg_rd                 = 1'b0;
    reg_addr               = 6'h00;
    reg_wdata              = 16'h0000;
    want_binsel            = 4'h0;
    want_speedbit          = 7'h00;
    want_jog               = 1'b0;
    want_run               = 1'b0;
    motor2_select          = 1'b0;
    forced_terminal_input  = 1'b0;
    forced_operation_input = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_registers();
    t_binary();
    t_bit();
    t_jog();
    t_run_first();
    t_motor2();
    tally_and_finish();
  end
endmodule // preset_speed_jog_selector_tb
